//--- pief_pkg.sv
`default_nettype none
package pief_pkg;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFF_EN_A = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_EN_B = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_EN_C = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_FL_A = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_FL_B = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_FL_C = 5'h14;
	localparam logic [ADDR_W-1:0] OFF_CORE = 5'h18;
	localparam logic [7:0] MASK_A = 8'hCB;
	localparam logic [7:0] MASK_B = 8'h6C;
	localparam logic [7:0] MASK_C = 8'h03;
	localparam int BIT_T1GATE = 7;
	localparam int BIT_ADC = 6;
	localparam int BIT_SERIAL = 3;
	localparam int BIT_T2MATCH = 1;
	localparam int BIT_T1OVF = 0;
	localparam int BIT_CMP_B = 6;
	localparam int BIT_CMP_A = 5;
	localparam int BIT_BUSCOL = 3;
	localparam int BIT_NUMOSC = 2;
	localparam int BIT_LC_B = 1;
	localparam int BIT_LC_A = 0;
	localparam int BIT_GLOBAL = 7;
	localparam int BIT_PGROUP = 6;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- pief_bank.sv
`default_nettype none
module pief_bank
	import pief_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hFF
)(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] event_i,
	input wire logic en_we_i,
	input wire logic fl_we_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] en_o,
	output logic [7:0] fl_o,
	output logic pend_o
);
	logic [7:0] en_r;
	logic [7:0] fl_r;
	logic [7:0] fl_nxt;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			en_r <= RST_REG;
		else if (en_we_i)
			en_r <= wdata_i & MASK;
	end

	always_comb
	begin
		fl_nxt = fl_r;
		if (fl_we_i)
			fl_nxt = wdata_i & MASK;
		fl_nxt = fl_nxt | (event_i & MASK);
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			fl_r <= RST_REG;
		else
			fl_r <= fl_nxt;
	end

	assign en_o = en_r;
	assign fl_o = fl_r;
	assign pend_o = |(en_r & fl_r);
endmodule // pief_bank
`default_nettype wire

//--- pief_top.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module pief_top
	import pief_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic [7:0] EVENT_A_I,
	input wire logic [7:0] EVENT_B_I,
	input wire logic [7:0] EVENT_C_I,
	input wire logic [4:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [4:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	output logic PERIPH_REQ_O,
	output logic CORE_IRQ_O
);
	logic aw_got_r;
	logic w_got_r;
	logic [4:0] aw_addr_r;
	logic [7:0] w_data_r;
	logic w_lane0_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [1:0] core_r;
	logic preq_r;
	logic creq_r;
	logic aw_rdy_r;
	logic w_rdy_r;
	logic ar_rdy_r;
	logic [7:0] ea_s1_r, ea_s2_r, eb_s1_r, eb_s2_r, ec_s1_r, ec_s2_r;
	logic [7:0] ea_prev_r, eb_prev_r, ec_prev_r;
	logic do_wr;
	logic [7:0] en_a, en_b, en_c, fl_a, fl_b, fl_c;
	logic pend_a, pend_b, pend_c;
	logic any_pend;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		return a[4:2] == off[4:2];
	endfunction

	function automatic logic mapped(input logic [4:0] a);
		return hit(a, OFF_EN_A) | hit(a, OFF_EN_B) | hit(a, OFF_EN_C) | hit(a, OFF_FL_A)
			| hit(a, OFF_FL_B) | hit(a, OFF_FL_C) | hit(a, OFF_CORE);
	endfunction

	// event pins synchronised, then rising edge taken
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			ea_s1_r <= 8'h00;
			ea_s2_r <= 8'h00;
			eb_s1_r <= 8'h00;
			eb_s2_r <= 8'h00;
			ec_s1_r <= 8'h00;
			ec_s2_r <= 8'h00;
			ea_prev_r <= 8'h00;
			eb_prev_r <= 8'h00;
			ec_prev_r <= 8'h00;
		end
		else
		begin
			ea_s1_r <= EVENT_A_I;
			ea_s2_r <= ea_s1_r;
			eb_s1_r <= EVENT_B_I;
			eb_s2_r <= eb_s1_r;
			ec_s1_r <= EVENT_C_I;
			ec_s2_r <= ec_s1_r;
			ea_prev_r <= ea_s2_r;
			eb_prev_r <= eb_s2_r;
			ec_prev_r <= ec_s2_r;
		end
	end

	// write address and data taken in either order
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= 5'h00;
			w_data_r <= 8'h00;
			w_lane0_r <= 1'b0;
		end
		else if (do_wr)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
		end
		else
		begin
			if (S_AXI_AWVALID_I && !aw_got_r)
			begin
				aw_got_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && !w_got_r)
			begin
				w_got_r <= 1'b1;
				w_data_r <= S_AXI_WDATA_I[7:0];
				w_lane0_r <= S_AXI_WSTRB_I[0];
			end
		end
	end

	assign do_wr = aw_got_r && w_got_r && !bvalid_r;

	// write readies held in flops, tracking the capture flags
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			aw_rdy_r <= 1'b1;
			w_rdy_r <= 1'b1;
		end
		else if (do_wr)
		begin
			aw_rdy_r <= 1'b1;
			w_rdy_r <= 1'b1;
		end
		else
		begin
			aw_rdy_r <= !(aw_got_r || S_AXI_AWVALID_I);
			w_rdy_r <= !(w_got_r || S_AXI_WVALID_I);
		end
	end

	// read ready low while read data is held
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
			ar_rdy_r <= 1'b1;
		else if (S_AXI_ARVALID_I && !rvalid_r)
			ar_rdy_r <= 1'b0;
		else if (S_AXI_RREADY_I)
			ar_rdy_r <= 1'b1;
	end

	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else if (do_wr)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_BREADY_I)
			bvalid_r <= 1'b0;
	end

	// core control: global and peripheral-group enables
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
			core_r <= 2'h0;
		else if (do_wr && w_lane0_r && hit(aw_addr_r, OFF_CORE))
			core_r <= {w_data_r[BIT_GLOBAL], w_data_r[BIT_PGROUP]};
	end

	pief_bank #(.MASK(MASK_A)) u_bank_a (
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.event_i(ea_s2_r & ~ea_prev_r),
		.en_we_i(do_wr && w_lane0_r && hit(aw_addr_r, OFF_EN_A)),
		.fl_we_i(do_wr && w_lane0_r && hit(aw_addr_r, OFF_FL_A)),
		.wdata_i(w_data_r),
		.en_o(en_a),
		.fl_o(fl_a),
		.pend_o(pend_a)
	);

	pief_bank #(.MASK(MASK_B)) u_bank_b (
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.event_i(eb_s2_r & ~eb_prev_r),
		.en_we_i(do_wr && w_lane0_r && hit(aw_addr_r, OFF_EN_B)),
		.fl_we_i(do_wr && w_lane0_r && hit(aw_addr_r, OFF_FL_B)),
		.wdata_i(w_data_r),
		.en_o(en_b),
		.fl_o(fl_b),
		.pend_o(pend_b)
	);

	pief_bank #(.MASK(MASK_C)) u_bank_c (
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.event_i(ec_s2_r & ~ec_prev_r),
		.en_we_i(do_wr && w_lane0_r && hit(aw_addr_r, OFF_EN_C)),
		.fl_we_i(do_wr && w_lane0_r && hit(aw_addr_r, OFF_FL_C)),
		.wdata_i(w_data_r),
		.en_o(en_c),
		.fl_o(fl_c),
		.pend_o(pend_c)
	);

	assign any_pend = pend_a | pend_b | pend_c;

	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			preq_r <= 1'b0;
			creq_r <= 1'b0;
		end
		else
		begin
			preq_r <= any_pend & core_r[0];
			creq_r <= any_pend & core_r[0] & core_r[1];
		end
	end

	// read channel
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID_I && !rvalid_r)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= mapped(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
			if (hit(S_AXI_ARADDR_I, OFF_EN_A))
				rdata_r <= {24'h000000, en_a};
			else if (hit(S_AXI_ARADDR_I, OFF_EN_B))
				rdata_r <= {24'h000000, en_b};
			else if (hit(S_AXI_ARADDR_I, OFF_EN_C))
				rdata_r <= {24'h000000, en_c};
			else if (hit(S_AXI_ARADDR_I, OFF_FL_A))
				rdata_r <= {24'h000000, fl_a};
			else if (hit(S_AXI_ARADDR_I, OFF_FL_B))
				rdata_r <= {24'h000000, fl_b};
			else if (hit(S_AXI_ARADDR_I, OFF_FL_C))
				rdata_r <= {24'h000000, fl_c};
			else if (hit(S_AXI_ARADDR_I, OFF_CORE))
				rdata_r <= {24'h000000, core_r[1], core_r[0], 6'h00};
			else
				rdata_r <= 32'h0000_0000;
		end
		else if (S_AXI_RREADY_I)
			rvalid_r <= 1'b0;
	end

	assign S_AXI_AWREADY_O = aw_rdy_r;
	assign S_AXI_WREADY_O = w_rdy_r;
	assign S_AXI_BVALID_O = bvalid_r;
	assign S_AXI_BRESP_O = bresp_r;
	assign S_AXI_ARREADY_O = ar_rdy_r;
	assign S_AXI_RVALID_O = rvalid_r;
	assign S_AXI_RDATA_O = rdata_r;
	assign S_AXI_RRESP_O = rresp_r;
	assign PERIPH_REQ_O = preq_r;
	assign CORE_IRQ_O = creq_r;

	AST_REQ_GATED: assert property (@(posedge CLK_I) disable iff (RESET_I)
		PERIPH_REQ_O |-> $past(core_r[0]))
		else $error("request without group enable");
	AST_REQ_FOLLOWS: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(any_pend && core_r[0]) |=> PERIPH_REQ_O)
		else $error("request not raised");
	AST_GLOBAL_OFF: assert property (@(posedge CLK_I) disable iff (RESET_I)
		!core_r[1] |=> !CORE_IRQ_O)
		else $error("core request while global off");
	AST_FLAG_SETS: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(ea_s2_r[BIT_ADC] && !ea_prev_r[BIT_ADC]) |=> fl_a[BIT_ADC])
		else $error("flag missed event");
	AST_UNIMPL_A: assert property (@(posedge CLK_I) disable iff (RESET_I)
		((en_a | fl_a) & ~MASK_A) == 8'h00)
		else $error("unimplemented bit set in bank a");
	AST_UNIMPL_B: assert property (@(posedge CLK_I) disable iff (RESET_I)
		((en_b | fl_b) & ~MASK_B) == 8'h00)
		else $error("unimplemented bit set in bank b");
	AST_UNIMPL_C: assert property (@(posedge CLK_I) disable iff (RESET_I)
		((en_c | fl_c) & ~MASK_C) == 8'h00)
		else $error("unimplemented bit set in bank c");
	AST_RESET_ZERO: assert property (@(posedge CLK_I)
		$past(RESET_I) |-> (en_a == 8'h00 && fl_b == 8'h00 && !PERIPH_REQ_O))
		else $error("not zero after reset");
	AST_FLAG_WRITE: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(do_wr && w_lane0_r && hit(aw_addr_r, OFF_FL_C) && w_data_r[0]) |=> fl_c[0])
		else $error("written flag not pending");
	COV_WRITE: cover property (@(posedge CLK_I) do_wr);
	COV_READ: cover property (@(posedge CLK_I) S_AXI_RVALID_O && S_AXI_RREADY_I);
	COV_REQ: cover property (@(posedge CLK_I) CORE_IRQ_O);
endmodule // pief_top
`default_nettype wire

//--- pief_evt_model.sv
`default_nettype none
module pief_evt_model (
	input wire logic clk_i,
	input wire logic fire_i,
	input wire logic [23:0] sel_i,
	output logic [23:0] event_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] cnt_r = 3'h0;
	// each fired source is high 3 cycles, then low
	always_ff @(posedge clk_i)
	begin
		if (fire_i)
			cnt_r <= 3'h6;
		else if (cnt_r != 3'h0)
			cnt_r <= cnt_r - 3'h1;
	end
	assign event_o = (cnt_r > 3'h3) ? sel_i : 24'h000000;
endmodule // pief_evt_model
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import pief_pkg::*;
	logic clk, rst, awv, wv, br, arv, rr, fire, awr, wr_r, bv, arr, rv, preq, cirq;
	logic [4:0] awa, ara;
	logic [31:0] wd, rd, rdat;
	logic [3:0] ws;
	logic [23:0] sel, ev, fl, en;
	logic [1:0] resp, bresp, rresp;
	logic [15:0] seed;
	int fails, checks, i, k;
	pief_evt_model i_evt (.clk_i(clk), .fire_i(fire), .sel_i(sel), .event_o(ev));
	pief_top i_dut (.CLK_I(clk), .RESET_I(rst), .EVENT_A_I(ev[7:0]), .EVENT_B_I(ev[15:8]),
		.EVENT_C_I(ev[23:16]), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara),
		.S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .PERIPH_REQ_O(preq), .CORE_IRQ_O(cirq));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [7:0] msk(input int n);
		return (n % 3 == 0) ? MASK_A : (n % 3 == 1) ? MASK_B : MASK_C;
	endfunction
	task final_report;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [4:0] a, input logic [7:0] dv, input logic [3:0] st);
		logic aw_t, w_t, b_t;
		@(posedge clk);
		awa <= a;
		awv <= 1'b1;
		wd <= {24'h000000, dv};
		ws <= st;
		wv <= 1'b1;
		br <= 1'b1;
		for (int n = 0; n < 40; n++)
		begin
			@(negedge clk);
			aw_t = awv & awr;
			w_t = wv & wr_r;
			b_t = bv & br;
			resp = bresp;
			@(posedge clk);
			if (aw_t)
				awv <= 1'b0;
			if (w_t)
				wv <= 1'b0;
			if (b_t)
			begin
				br <= 1'b0;
				return;
			end
		end
		fails++;
		final_report();
	endtask
	task rdr(input logic [4:0] a);
		logic ar_t, r_t;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		for (int n = 0; n < 40; n++)
		begin
			@(negedge clk);
			ar_t = arv & arr;
			r_t = rv & rr;
			rd = rdat;
			resp = rresp;
			@(posedge clk);
			if (ar_t)
				arv <= 1'b0;
			if (r_t)
			begin
				rr <= 1'b0;
				return;
			end
		end
		fails++;
		final_report();
	endtask
	task pulse(input logic [23:0] v);
		@(posedge clk);
		sel <= v;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
	task reqs(input logic p, input logic c);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({31'h0, preq}, {31'h0, p});
		chk({31'h0, cirq}, {31'h0, c});
	endtask
	initial
	begin
		{awv, wv, br, arv, rr, fire} = 6'h00;
		{awa, ara, ws, wd, sel} = '0;
		rst = 1'b1;
		fails = 0;
		checks = 0;
		seed = 16'h2387;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 7; i++)
		begin
			rdr(5'(i * 4));
			chk(rd, 32'h0);
		end
		for (i = 0; i < 6; i++)
			for (k = 0; k < 3; k++)
			begin
				seed = lfsr(seed);
				wd[7:0] = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : seed[7:0];
				wr(5'(i * 4), wd[7:0], 4'hF);
				chk({30'h0, resp}, {30'h0, RESP_OKAY});
				rdr(5'(i * 4));
				chk(rd, {24'h0, wd[7:0] & msk(i)});
			end
		wr(OFF_EN_A, 8'h00, 4'hF);
		wr(OFF_EN_A, 8'hFF, 4'h0);
		rdr(OFF_EN_A);
		chk(rd, 32'h0);
		wr(5'h1C, 8'hFF, 4'hF);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		rdr(5'h1C);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		chk(rd, 32'h0);
		for (k = 0; k < 8; k++)
		begin
			seed = lfsr(seed);
			en = {seed[7:0], seed[15:0]} & {MASK_C, MASK_B, MASK_A};
			seed = lfsr(seed);
			fl = (k == 0) ? 24'hFFFFFF : {seed[15:8], seed[15:0]};
			for (i = 3; i < 6; i++)
				wr(5'(i * 4), 8'h00, 4'hF);
			for (i = 0; i < 3; i++)
				wr(5'(i * 4), en[i*8 +: 8], 4'hF);
			wr(OFF_CORE, {k[0], 1'b1, 6'h00}, 4'hF);
			pulse(fl);
			fl = fl & {MASK_C, MASK_B, MASK_A};
			for (i = 0; i < 3; i++)
			begin
				rdr(5'((i + 3) * 4));
				chk(rd, {24'h0, fl[i*8 +: 8]});
			end
			reqs(|(fl & en), (|(fl & en)) & k[0]);
		end
		wr(OFF_EN_A, 8'h01, 4'hF);
		wr(OFF_FL_A, 8'h01, 4'hF);
		wr(OFF_CORE, 8'h00, 4'hF);
		reqs(1'b0, 1'b0);
		wr(OFF_CORE, 8'h40, 4'hF);
		reqs(1'b1, 1'b0);
		wr(OFF_CORE, 8'hC0, 4'hF);
		reqs(1'b1, 1'b1);
		wr(OFF_FL_A, 8'h00, 4'hF);
		reqs(1'b0, 1'b0);
		pulse(24'h000001);
		reqs(1'b1, 1'b1);
		final_report();
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		fails++;
		final_report();
	end
endmodule // testbench
`default_nettype wire
